//--- srp_params.svh
// Purpose: constants of the two-wire register port
// Assumes: 8-bit register pointer and data bytes
// Notes: offsets, reset values and counts only
`ifndef SRP_PARAMS_SVH
`define SRP_PARAMS_SVH

`define SRP_ADDR_BASE 7'h4C
`define SRP_BLOCKED_IDX 8'h0F
`define SRP_PTR_RST 8'h00
`define SRP_REG_RST 8'h00
`define SRP_SHIFT_RST 8'h00
`define SRP_BIT_RST 4'h0
`define SRP_BIT_LAST 4'h8
`define SRP_BIT_STEP 4'h1
`define SRP_PTR_STEP 8'h01
`define SRP_LINE_RST 2'h3
`define SRP_STRAP_RST 2'h0
`define SRP_SLEEP_RST 1'h1

`endif

//--- srp_pkg.sv
// Purpose: types of the two-wire register port
// Assumes: nothing beyond the params header
// Notes: state codes are gray along the usual path
package srp_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RECV = 3'h1,
        ST_ACK = 3'h3,
        ST_SEND = 3'h2,
        ST_RACK = 3'h6,
        ST_WAIT = 3'h7
    } srp_state_e;

    typedef enum logic [1:0] {
        PH_ADDR = 2'h0,
        PH_PTR = 2'h1,
        PH_DATA = 2'h3
    } srp_phase_e;

endpackage

//--- srp_sync.sv
// Purpose: three-flop pin synchroniser with agreement filter
// Assumes: input is asynchronous to clk_sys_i
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module srp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // per-bit agreement, so one noisy line does not hold back another
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk_sys_i or negedge resetn_i) begin
            if (!resetn_i) begin
                level_o[i] <= RST_VAL[i];
            end else if (s2_reg[i] == s3_reg[i]) begin
                level_o[i] <= s3_reg[i];
            end
        end
    end

endmodule // srp_sync

`default_nettype wire

//--- srp_regfile.sv
// Purpose: byte-wide control register array
// Assumes: one write port, one combinational read port
// Notes: writes are frozen while sleep is requested
`timescale 1ns/1ps
`default_nettype none
`include "srp_params.svh"

module srp_regfile #(
    parameter int REG_DEPTH = 256
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic sleep_n_i,
    input wire logic wr_en_i,
    input wire logic [7:0] wr_idx_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [7:0] rd_idx_i,
    output logic [7:0] rd_data_o
);

    logic [7:0] mem [REG_DEPTH];
    logic [7:0] cur_byte;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < REG_DEPTH; i++) begin
                mem[i] <= `SRP_REG_RST;
            end
        end else if (wr_en_i && sleep_n_i) begin
            mem[wr_idx_i] <= wr_data_i;
        end
    end

    assign rd_data_o = mem[rd_idx_i];
    assign cur_byte = mem[wr_idx_i];

    property p_sleep_hold;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (!sleep_n_i && wr_en_i) |=> (mem[$past(wr_idx_i)] == $past(cur_byte));
    endproperty
    AST_SLEEP_HOLD: assert property (p_sleep_hold) else $error("register changed during sleep");

    property p_store;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (sleep_n_i && wr_en_i) |=> (mem[$past(wr_idx_i)] == $past(wr_data_i));
    endproperty
    AST_STORE: assert property (p_store) else $error("written byte not stored");

endmodule // srp_regfile

`default_nettype wire

//--- srp_serial_port.sv
// Purpose: two-wire serial slave giving access to control registers
// Assumes: master drives scl; sda is open drain, resolved outside
// Notes: both lines oversampled on clk_sys_i; no link clock domain
//
// Overview of operation
// - strap pins pick address 4C to 4F
// - slave only, never drives clock line
// - sda changes only while scl low
// - idle bus rests high, released
// - start condition begins address reception
// - first byte: address plus direction bit
// - matching address acknowledged on ninth pulse
// - no acknowledge on mismatch or index 0F
// - bytes shifted most significant bit first
// - refused write leaves sda released high
// - master high ack ends read data
// - write: address, pointer, then data bytes
// - pointer increments after each written byte
// - read: pointer write, restart, read address
// - pointer increments after each read byte
// - stop condition returns device to idle
// - repeated start begins new address phase
// - sleep request freezes register contents
`timescale 1ns/1ps
`default_nettype none
`include "srp_params.svh"

module srp_serial_port #(
    parameter int REG_DEPTH = 256
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [1:0] bus_id_select_pins_i,
    input wire logic sleep_request_n_i,
    output logic busy_o
);

    logic scl_s;
    logic sda_s;
    logic [1:0] strap_s;
    logic sleep_n_s;
    logic scl_d_reg;
    logic sda_d_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    srp_pkg::srp_state_e state_reg;
    srp_pkg::srp_phase_e phase_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [7:0] ptr_reg;
    logic [7:0] rd_data;
    logic [6:0] own_addr;
    logic dir_reg;
    logic mack_reg;
    logic byte_done;
    logic ack_ok;
    logic wr_en;
    logic ack_end;
    logic send_end;
    logic rack_next;

    function automatic logic is_blocked(input logic [7:0] idx);
        is_blocked = (idx == `SRP_BLOCKED_IDX);
    endfunction

    srp_sync #(
        .WIDTH(2),
        .RST_VAL(`SRP_LINE_RST)
    ) u_line_sync (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .pin_i({scl_i, sda_i}),
        .level_o({scl_s, sda_s})
    );

    srp_sync #(
        .WIDTH(2),
        .RST_VAL(`SRP_STRAP_RST)
    ) u_strap_sync (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .pin_i(bus_id_select_pins_i),
        .level_o(strap_s)
    );

    srp_sync #(
        .RST_VAL(`SRP_SLEEP_RST)
    ) u_sleep_sync (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .pin_i(sleep_request_n_i),
        .level_o(sleep_n_s)
    );

    srp_regfile #(
        .REG_DEPTH(REG_DEPTH)
    ) u_regs (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .sleep_n_i(sleep_n_s),
        .wr_en_i(wr_en),
        .wr_idx_i(ptr_reg),
        .wr_data_i(shift_reg),
        .rd_idx_i(ptr_reg),
        .rd_data_o(rd_data)
    );

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    // sda moving while scl stays high is framing, never data
    assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    assign own_addr = `SRP_ADDR_BASE | {5'h00, strap_s};

    assign byte_done = (state_reg == srp_pkg::ST_RECV) && scl_fall && (bit_cnt_reg == `SRP_BIT_LAST);

    // read address refused when the pointer already sits on the blocked index
    always_comb begin
        ack_ok = 1'b0;
        case (phase_reg)
            srp_pkg::PH_ADDR: ack_ok = (shift_reg[7:1] == own_addr) && !(shift_reg[0] && is_blocked(ptr_reg));
            srp_pkg::PH_PTR: ack_ok = !is_blocked(shift_reg);
            srp_pkg::PH_DATA: ack_ok = !is_blocked(ptr_reg);
            default: ack_ok = 1'b0;
        endcase
    end

    assign wr_en = byte_done && ack_ok && (phase_reg == srp_pkg::PH_DATA);
    assign ack_end = (state_reg == srp_pkg::ST_ACK) && scl_fall;
    assign send_end = (state_reg == srp_pkg::ST_SEND) && scl_fall && (bit_cnt_reg == `SRP_BIT_LAST);
    assign rack_next = (state_reg == srp_pkg::ST_RACK) && scl_fall && mack_reg;

    // start wins in every state, which also covers a repeated start
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= srp_pkg::ST_IDLE;
            phase_reg <= srp_pkg::PH_ADDR;
            bit_cnt_reg <= `SRP_BIT_RST;
            dir_reg <= 1'b0;
            mack_reg <= 1'b0;
        end else if (start_det) begin
            state_reg <= srp_pkg::ST_RECV;
            phase_reg <= srp_pkg::PH_ADDR;
            bit_cnt_reg <= `SRP_BIT_RST;
        end else if (stop_det) begin
            state_reg <= srp_pkg::ST_IDLE;
        end else begin
            case (state_reg)
                srp_pkg::ST_RECV: begin
                    if (scl_rise && (bit_cnt_reg != `SRP_BIT_LAST)) begin
                        bit_cnt_reg <= bit_cnt_reg + `SRP_BIT_STEP;
                    end else if (byte_done) begin
                        state_reg <= ack_ok ? srp_pkg::ST_ACK : srp_pkg::ST_WAIT;
                        if (phase_reg == srp_pkg::PH_ADDR) begin
                            dir_reg <= shift_reg[0];
                        end
                    end
                end
                srp_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= `SRP_BIT_RST;
                        if (dir_reg) begin
                            state_reg <= srp_pkg::ST_SEND;
                        end else begin
                            state_reg <= srp_pkg::ST_RECV;
                            phase_reg <= (phase_reg == srp_pkg::PH_ADDR) ? srp_pkg::PH_PTR : srp_pkg::PH_DATA;
                        end
                    end
                end
                srp_pkg::ST_SEND: begin
                    if (scl_rise && (bit_cnt_reg != `SRP_BIT_LAST)) begin
                        bit_cnt_reg <= bit_cnt_reg + `SRP_BIT_STEP;
                    end else if (send_end) begin
                        state_reg <= srp_pkg::ST_RACK;
                        mack_reg <= 1'b0;
                    end
                end
                srp_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            state_reg <= srp_pkg::ST_WAIT;
                        end else begin
                            mack_reg <= 1'b1;
                        end
                    end else if (rack_next) begin
                        state_reg <= srp_pkg::ST_SEND;
                        bit_cnt_reg <= `SRP_BIT_RST;
                    end
                end
                srp_pkg::ST_WAIT: state_reg <= srp_pkg::ST_WAIT;
                srp_pkg::ST_IDLE: state_reg <= srp_pkg::ST_IDLE;
                default: state_reg <= srp_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shift_reg <= `SRP_SHIFT_RST;
        end else if ((state_reg == srp_pkg::ST_RECV) && scl_rise && (bit_cnt_reg != `SRP_BIT_LAST)) begin
            shift_reg <= {shift_reg[6:0], sda_s};
        end
    end

    // pointer survives stop and restart so a read can follow a pointer write
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ptr_reg <= `SRP_PTR_RST;
        end else if (byte_done && ack_ok && (phase_reg == srp_pkg::PH_PTR)) begin
            ptr_reg <= shift_reg;
        end else if (wr_en || send_end) begin
            ptr_reg <= ptr_reg + `SRP_PTR_STEP;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_reg <= `SRP_SHIFT_RST;
        end else if ((ack_end && dir_reg) || rack_next) begin
            tx_reg <= rd_data;
        end else if ((state_reg == srp_pkg::ST_SEND) && scl_fall && (bit_cnt_reg != `SRP_BIT_LAST)) begin
            tx_reg <= {tx_reg[6:0], 1'b0};
        end
    end

    // drive changes only one sample after scl is seen low
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sda_oe_o <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_oe_o <= 1'b0;
        end else if (byte_done) begin
            sda_oe_o <= ack_ok;
        end else if (ack_end) begin
            sda_oe_o <= dir_reg & ~rd_data[7];
        end else if (rack_next) begin
            sda_oe_o <= ~rd_data[7];
        end else if (send_end) begin
            sda_oe_o <= 1'b0;
        end else if ((state_reg == srp_pkg::ST_SEND) && scl_fall) begin
            sda_oe_o <= ~tx_reg[6];
        end else if ((state_reg == srp_pkg::ST_IDLE) || (state_reg == srp_pkg::ST_WAIT)) begin
            sda_oe_o <= 1'b0;
        end
    end

    // open drain: the line is only ever pulled low, scl has no driver at all
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= (state_reg != srp_pkg::ST_IDLE);
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_addr_byte;
        byte_done && (phase_reg == srp_pkg::PH_ADDR);
    endsequence

    sequence s_read_ack_end;
        ack_end && dir_reg;
    endsequence

    sequence s_master_nack;
        (state_reg == srp_pkg::ST_RACK) && scl_rise && sda_s && !start_det && !stop_det;
    endsequence

    // read address while the pointer rests on the refused index
    sequence s_read_blocked;
        byte_done && (phase_reg == srp_pkg::PH_ADDR) && shift_reg[0] && (ptr_reg == `SRP_BLOCKED_IDX);
    endsequence

    AST_START_RECV: assert property (start_det |=> (state_reg == srp_pkg::ST_RECV) && (bit_cnt_reg == 4'h0)
        && (phase_reg == srp_pkg::PH_ADDR)) else $error("start not followed by address reception");

    AST_STOP_IDLE: assert property (stop_det |=> (state_reg == srp_pkg::ST_IDLE) ##1 !sda_oe_o)
        else $error("stop not followed by idle");

    AST_ACK_MATCH: assert property ((s_addr_byte and (shift_reg[7:1] == own_addr) and !shift_reg[0])
        |=> sda_oe_o && (state_reg == srp_pkg::ST_ACK)) else $error("matching address not acknowledged");

    AST_NACK_MISMATCH: assert property ((s_addr_byte and (shift_reg[7:1] != own_addr))
        |=> !sda_oe_o && (state_reg == srp_pkg::ST_WAIT)) else $error("foreign address acknowledged");

    AST_NACK_BLOCKED: assert property ((byte_done && (phase_reg == srp_pkg::PH_PTR) && (shift_reg == 8'h0F))
        |=> !sda_oe_o [*2]) else $error("blocked index acknowledged");

    AST_NACK_RD_BLOCKED: assert property (s_read_blocked |=> !sda_oe_o && (state_reg == srp_pkg::ST_WAIT))
        else $error("read of blocked index acknowledged");

    AST_WAIT_RELEASED: assert property ((state_reg == srp_pkg::ST_WAIT) && $past(state_reg == srp_pkg::ST_WAIT)
        |-> !sda_oe_o) else $error("sda pulled after refusal");

    AST_WR_INC: assert property (wr_en |=> (ptr_reg == 8'($past(ptr_reg) + 8'h01)))
        else $error("pointer not advanced after write");

    AST_RD_INC: assert property (send_end |=> (ptr_reg == 8'($past(ptr_reg) + 8'h01))
        && (state_reg == srp_pkg::ST_RACK) && !sda_oe_o) else $error("pointer not advanced after read");

    AST_SEND_MSB: assert property (s_read_ack_end |=> (sda_oe_o == !$past(rd_data[7]))
        && (tx_reg == $past(rd_data))) else $error("read byte not started with msb");

    AST_END_DATA: assert property (s_master_nack |=> (state_reg == srp_pkg::ST_WAIT) ##1 !sda_oe_o)
        else $error("master nack did not end read");

    AST_SDA_SCL_LOW: assert property ($changed(sda_oe_o) && !$past(start_det) && !$past(stop_det) |-> !scl_d_reg)
        else $error("sda drive moved while scl high");

endmodule // srp_serial_port

`default_nettype wire

//--- srp_host_model.sv
// Purpose: behavioural two-wire bus master for the register port
// Assumes: caller steps on clk_sys_i falling edges; bus resolved outside
// Notes: scl period 16 clocks, low and high 8 clocks each
`timescale 1ns/1ps
`default_nettype none

module srp_host_model (
    input wire logic clk_sys_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_pull_o
);
    int glitch_cnt;

    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
        glitch_cnt = 0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    // line taken at end of high phase; a change while high is counted
    task automatic bit_xfer(input logic pull, output logic seen);
        logic first;
        wait_clk(4);
        sda_pull_o = pull;
        wait_clk(4);
        scl_o = 1'b1;
        wait_clk(1);
        first = sda_i;
        wait_clk(7);
        seen = sda_i;
        if (seen !== first) glitch_cnt++;
        scl_o = 1'b0;
    endtask

    // also serves as repeated start when scl is low
    task automatic start_cond();
        wait_clk(4);
        sda_pull_o = 1'b0;
        wait_clk(4);
        scl_o = 1'b1;
        wait_clk(8);
        sda_pull_o = 1'b1;
        wait_clk(8);
        scl_o = 1'b0;
    endtask

    task automatic stop_cond();
        wait_clk(4);
        sda_pull_o = 1'b1;
        wait_clk(4);
        scl_o = 1'b1;
        wait_clk(8);
        sda_pull_o = 1'b0;
        wait_clk(8);
    endtask

    task automatic write_byte(input logic [7:0] b, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(~b[i], s);
        end
        bit_xfer(1'b0, s);
        acked = ~s;
    endtask

    // low ack asks for more bytes, high ack ends the read
    task automatic read_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b0, b[i]);
        end
        bit_xfer(~last, s);
    endtask
endmodule // srp_host_model

`default_nettype wire

//--- serial_register_port_bench.sv
// Purpose: self-checking bench of the two-wire register port
// Assumes: host model drives scl and pulls sda; sda has a pull-up
// Notes: default strap gives slave address 4C
`timescale 1ns/1ps
`default_nettype none

module serial_register_port_bench;
    typedef logic [7:0] srp_bytes_t [$];
    localparam logic [6:0] SLV = 7'h4C;
    logic clk_sys_i, resetn_i, sda_o, sda_oe_o, busy_o, sleep_n, scl, pull, sda_wire;
    logic [1:0] strap;
    int n_errors, n_checks;
    srp_bytes_t q;
    logic a;

    assign sda_wire = (sda_oe_o ? sda_o : 1'b1) & ~pull;

    srp_serial_port u_dut (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_wire),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .bus_id_select_pins_i(strap),
        .sleep_request_n_i(sleep_n), .busy_o(busy_o)
    );

    srp_host_model u_host (
        .clk_sys_i(clk_sys_i), .sda_i(sda_wire), .scl_o(scl), .sda_pull_o(pull)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic put_regs(input logic [7:0] ptr, input srp_bytes_t d);
        u_host.start_cond();
        u_host.write_byte({SLV, 1'b0}, a);
        chk("write address ack", 8'h01, {7'h00, a});
        u_host.write_byte(ptr, a);
        chk("pointer ack", 8'h01, {7'h00, a});
        foreach (d[i]) begin
            u_host.write_byte(d[i], a);
            chk("data ack", 8'h01, {7'h00, a});
        end
        u_host.stop_cond();
    endtask

    // pointer write, optional stop, then restart with read direction
    task automatic get_regs(input logic [7:0] ptr, input int n, input logic use_stop, output srp_bytes_t r);
        logic [7:0] b;
        r = {};
        u_host.start_cond();
        u_host.write_byte({SLV, 1'b0}, a);
        u_host.write_byte(ptr, a);
        if (use_stop) u_host.stop_cond();
        u_host.start_cond();
        u_host.write_byte({SLV, 1'b1}, a);
        chk("read address ack", 8'h01, {7'h00, a});
        for (int i = 0; i < n; i++) begin
            u_host.read_byte(i == n - 1, b);
            r.push_back(b);
        end
        // give the device time to react to the high ack before judging the line
        u_host.wait_clk(6);
        chk("sda released after last read", 8'h00, {7'h00, sda_oe_o});
        u_host.stop_cond();
    endtask

    task automatic t_idle();
        chk("idle sda enable", 8'h00, {7'h00, sda_oe_o});
        chk("idle busy", 8'h00, {7'h00, busy_o});
        chk("idle sda line", 8'h01, {7'h00, sda_wire});
    endtask

    task automatic t_strap();
        for (int p = 0; p < 4; p++) begin
            strap = p[1:0];
            u_host.wait_clk(8);
            u_host.start_cond();
            chk("busy after start", 8'h01, {7'h00, busy_o});
            u_host.write_byte({SLV + 7'(p), 1'b0}, a);
            chk("strap address ack", 8'h01, {7'h00, a});
            u_host.stop_cond();
            chk("busy after stop", 8'h00, {7'h00, busy_o});
            u_host.start_cond();
            u_host.write_byte({SLV + 7'((p + 1) % 4), 1'b0}, a);
            chk("foreign address ack", 8'h00, {7'h00, a});
            u_host.stop_cond();
        end
        strap = 2'h0;
        u_host.wait_clk(8);
    endtask

    task automatic t_burst();
        put_regs(8'h10, '{8'hA5, 8'h3C, 8'h81, 8'h7E});
        get_regs(8'h10, 4, 1'b0, q);
        chk("burst byte 0", 8'hA5, q[0]);
        chk("burst byte 1", 8'h3C, q[1]);
        chk("burst byte 2", 8'h81, q[2]);
        chk("burst byte 3", 8'h7E, q[3]);
        get_regs(8'h12, 1, 1'b1, q);
        chk("read after stop", 8'h81, q[0]);
    endtask

    task automatic t_wrap();
        put_regs(8'hFF, '{8'h11, 8'h22});
        get_regs(8'hFF, 2, 1'b0, q);
        chk("top index", 8'h11, q[0]);
        chk("wrapped to zero", 8'h22, q[1]);
    endtask

    task automatic t_blocked();
        u_host.start_cond();
        u_host.write_byte({SLV, 1'b0}, a);
        u_host.write_byte(8'h0F, a);
        chk("blocked pointer ack", 8'h00, {7'h00, a});
        u_host.write_byte(8'h55, a);
        chk("ignored data ack", 8'h00, {7'h00, a});
        u_host.stop_cond();
        u_host.start_cond();
        u_host.write_byte({SLV, 1'b0}, a);
        u_host.write_byte(8'h0E, a);
        u_host.write_byte(8'h66, a);
        chk("byte below blocked ack", 8'h01, {7'h00, a});
        u_host.write_byte(8'h77, a);
        chk("run into blocked ack", 8'h00, {7'h00, a});
        u_host.stop_cond();
        u_host.start_cond();
        u_host.write_byte({SLV, 1'b1}, a);
        chk("blocked read address ack", 8'h00, {7'h00, a});
        u_host.stop_cond();
        get_regs(8'h0E, 1, 1'b1, q);
        chk("byte below blocked", 8'h66, q[0]);
    endtask

    task automatic t_sleep();
        put_regs(8'h20, '{8'hC3, 8'h3C});
        sleep_n = 1'b0;
        u_host.wait_clk(8);
        put_regs(8'h20, '{8'h5A, 8'h5B});
        sleep_n = 1'b1;
        u_host.wait_clk(8);
        get_regs(8'h20, 2, 1'b1, q);
        chk("held during sleep", 8'hC3, q[0]);
        chk("held during sleep next", 8'h3C, q[1]);
    endtask

    initial begin
        #400_000;
        n_errors++;
        $display("[ERR] watchdog expected done seen timeout");
        end_sim();
    end

    initial begin
        n_errors = 0;
        n_checks = 0;
        resetn_i = 1'b0;
        strap = 2'h0;
        sleep_n = 1'b1;
        repeat (5) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        u_host.wait_clk(8);
        t_idle();
        t_strap();
        t_burst();
        t_wrap();
        t_blocked();
        t_sleep();
        chk("sda steady while scl high", 8'h00, u_host.glitch_cnt[7:0]);
        end_sim();
    end
endmodule // serial_register_port_bench

`default_nettype wire
